// *** rtl/dics_defs.svh ***
// constants for the drive input command selector
// assumes a single 200 MHz clock; included by the package and the top
`ifndef DICS_DEFS_SVH
`define DICS_DEFS_SVH
`define DICS_TERM_COUNT       10
`define DICS_FUNC_W           8
`define DICS_FREQ_W           16
`define DICS_FN_LOCAL_REMOTE  8'h01
`define DICS_FN_BB_NO         8'h08
`define DICS_FN_BB_NC         8'h09
`define DICS_FN_RAMP_HOLD     8'h0A
`define DICS_FN_UP_CMD        8'h10
`define DICS_FN_DOWN_CMD      8'h11
`define DICS_FN_RESET         8'h0F
`define DICS_SRC_RESET        2'h1
`define DICS_MEM_RESET        1'b0
`define DICS_KEY_REMOTE_RESET 1'b1
`define DICS_ADDR_CTRL        12'h000
`define DICS_ADDR_STATUS      12'h004
`define DICS_ADDR_FREQ_IN     12'h008
`define DICS_ADDR_OUT_FREQ    12'h00C
`define DICS_ADDR_HELD        12'h010
`define DICS_ADDR_TERM_BASE   12'h040
`define DICS_ADDR_TERM_LAST   12'h064
`define DICS_CTRL_FREQ_LSB    0
`define DICS_CTRL_RUN_LSB     4
`define DICS_CTRL_MEM_BIT     8
`define DICS_CTRL_KEY_BIT     9
`endif

// *** rtl/dics_pkg.sv ***
// types for the drive input command selector
// constants live in dics_defs.svh
`include "dics_defs.svh"
package dics_pkg;
   typedef enum logic [1:0] {
      DICS_SRC_KEYPAD,
      DICS_SRC_TERMINAL,
      DICS_SRC_SERIAL,
      DICS_SRC_OPTION
   } dics_src_t;
   typedef enum logic [1:0] {
      DICS_ST_IDLE,
      DICS_ST_RUN,
      DICS_ST_BLOCKED,
      DICS_ST_SEARCH
   } dics_state_t;
endpackage : dics_pkg

// *** rtl/dics_top.sv ***
// drive input command selector: terminal functions and source routing
// assumes an APB master on ref_clk_i, contacts asynchronous to the clock
//
// Function
// - terminal code 1 picks keypad or remote
// - reference source codes 0..3, default 1
// - run source codes 0..3, default 1
// - keypad local key ignored when terminal assigned
// - code 8 terminal on inhibits output
// - code 9 terminal off inhibits output
// - inhibit release resumes with speed search
// - code A freezes ramp, latches frequency
// - memory selector 0 starts zero, 1 held
// - selector 1 and hold keep frequency stored
// - memory selector needs hold or up/down
// - selector 0 run during hold forces zero
// - ten terminal function selectors
//
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`include "dics_defs.svh"
module dics_top (
   // clock and reset
   input  wire logic                         ref_clk_i,
   input  wire logic                         reset_i,
   // apb slave
   input  wire logic                         psel_i,
   input  wire logic                         penable_i,
   input  wire logic                         pwrite_i,
   input  wire logic [11:0]                  paddr_i,
   input  wire logic [31:0]                  pwdata_i,
   output logic      [31:0]                  prdata_o,
   output logic                              pready_o,
   output logic                              pslverr_o,
   // contact inputs
   input  wire logic [`DICS_TERM_COUNT-1:0]  multi_input_i,
   input  wire logic                         forward_run_input_i,
   input  wire logic                         reverse_run_input_i,
   // source commands from keypad, analog terminal, serial link and option board
   input  wire logic                         keypad_local_key_i,
   input  wire logic                         keypad_run_i,
   input  wire logic                         serial_run_i,
   input  wire logic                         option_run_i,
   input  wire logic [`DICS_FREQ_W-1:0]      analog_ref_i,
   input  wire logic [`DICS_FREQ_W-1:0]      serial_ref_i,
   input  wire logic [`DICS_FREQ_W-1:0]      option_ref_i,
   // ramp generator feedback
   input  wire logic [`DICS_FREQ_W-1:0]      ramp_freq_i,
   input  wire logic                         search_done_i,
   // non-volatile store of the held frequency
   input  wire logic [`DICS_FREQ_W-1:0]      nv_freq_i,
   input  wire logic                         nv_valid_i,
   output logic                              nv_write_o,
   output logic      [`DICS_FREQ_W-1:0]      nv_data_o,
   // drive commands
   output dics_pkg::dics_src_t               active_ref_src_o,
   output dics_pkg::dics_src_t               active_run_src_o,
   output logic      [`DICS_FREQ_W-1:0]      freq_ref_o,
   output logic                              run_cmd_o,
   output logic                              output_inhibit_o,
   output logic                              ramp_hold_o,
   output logic                              speed_search_o,
   output logic                              force_zero_o
);
   import dics_pkg::*;

   localparam int N = `DICS_TERM_COUNT;

   // one bit per terminal selector, set where that selector holds the given code
   function automatic logic [N-1:0] fn_match(
      input logic [N*`DICS_FUNC_W-1:0] sel,
      input logic [`DICS_FUNC_W-1:0]   code);
      logic [N-1:0] m;
      m = '0;
      for (int i = 0; i < N; i++) begin
         m[i] = (sel[i*`DICS_FUNC_W +: `DICS_FUNC_W] == code);
      end
      return m;
   endfunction : fn_match

   // registers
   logic [N*`DICS_FUNC_W-1:0] input_terminal_function_sel_q;
   dics_src_t                 freq_ref_source_sel_q;
   dics_src_t                 run_cmd_source_sel_q;
   logic                      hold_freq_memory_sel_q;
   logic                      key_remote_q;
   logic [`DICS_FREQ_W-1:0]   keypad_freq_q;
   logic [`DICS_FREQ_W-1:0]   held_reference_memory_q;
   logic [`DICS_FREQ_W-1:0]   bb_freq_q;
   logic                      nv_loaded_q;
   dics_state_t               state_q;
   logic                      run_q;

   // two-stage synchronisers
   logic [N+1:0] sync1_q;
   logic [N+1:0] sync2_q;

   always_ff @(posedge ref_clk_i) begin
      sync1_q <= {reverse_run_input_i, forward_run_input_i, multi_input_i};
      sync2_q <= sync1_q;
   end

   logic [N-1:0] term;
   logic         fwd_in;
   logic         rev_in;
   assign term   = sync2_q[N-1:0];
   assign fwd_in = sync2_q[N];
   assign rev_in = sync2_q[N+1];

   // terminal function decode
   logic [N-1:0] m_lr;
   logic [N-1:0] m_bbno;
   logic [N-1:0] m_bbnc;
   logic [N-1:0] m_hold;
   logic         updown_set;
   logic         lr_assigned;
   logic         remote;
   logic         inhibit;
   logic         hold;
   logic         mem_on;

   always_comb begin
      m_lr   = fn_match(input_terminal_function_sel_q, `DICS_FN_LOCAL_REMOTE);
      m_bbno = fn_match(input_terminal_function_sel_q, `DICS_FN_BB_NO);
      m_bbnc = fn_match(input_terminal_function_sel_q, `DICS_FN_BB_NC);
      m_hold = fn_match(input_terminal_function_sel_q, `DICS_FN_RAMP_HOLD);
      updown_set = |(fn_match(input_terminal_function_sel_q, `DICS_FN_UP_CMD) |
                     fn_match(input_terminal_function_sel_q, `DICS_FN_DOWN_CMD));
   end

   assign lr_assigned = |m_lr;
   // terminal alone decides when assigned; keypad key ignored then
   assign remote  = lr_assigned ? |(m_lr & term) : key_remote_q;
   assign inhibit = |(m_bbno & term) | |(m_bbnc & ~term);
   assign hold    = |(m_hold & term);
   assign mem_on  = hold_freq_memory_sel_q & (|m_hold | updown_set);

   // source routing: local means keypad for both paths
   dics_src_t ref_src;
   dics_src_t run_src;
   assign ref_src = remote ? freq_ref_source_sel_q : DICS_SRC_KEYPAD;
   assign run_src = remote ? run_cmd_source_sel_q : DICS_SRC_KEYPAD;

   logic [`DICS_FREQ_W-1:0] sel_ref;
   logic                    sel_run;
   always_comb begin
      case (ref_src)
         DICS_SRC_KEYPAD:   sel_ref = keypad_freq_q;
         DICS_SRC_TERMINAL: sel_ref = analog_ref_i;
         DICS_SRC_SERIAL:   sel_ref = serial_ref_i;
         DICS_SRC_OPTION:   sel_ref = option_ref_i;
         default:           sel_ref = analog_ref_i;
      endcase
      case (run_src)
         DICS_SRC_KEYPAD:   sel_run = keypad_run_i;
         DICS_SRC_TERMINAL: sel_run = fwd_in | rev_in;
         DICS_SRC_SERIAL:   sel_run = serial_run_i;
         DICS_SRC_OPTION:   sel_run = option_run_i;
         default:           sel_run = fwd_in | rev_in;
      endcase
   end

   // run / inhibit / speed-search sequence
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         state_q   <= DICS_ST_IDLE;
         bb_freq_q <= '0;
      end else begin
         case (state_q)
            DICS_ST_IDLE: begin
               if (sel_run) state_q <= DICS_ST_RUN;
            end
            DICS_ST_RUN: begin
               if (inhibit) begin
                  state_q   <= DICS_ST_BLOCKED;
                  bb_freq_q <= sel_ref;
               end else if (!sel_run) begin
                  state_q <= DICS_ST_IDLE;
               end
            end
            DICS_ST_BLOCKED: begin
               if (!inhibit) state_q <= sel_run ? DICS_ST_SEARCH : DICS_ST_IDLE;
            end
            DICS_ST_SEARCH: begin
               if (inhibit) state_q <= DICS_ST_BLOCKED;
               else if (search_done_i) state_q <= DICS_ST_RUN;
            end
            default: state_q <= DICS_ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) run_q <= 1'b0;
      else         run_q <= sel_run;
   end

   logic run_rise;
   assign run_rise = sel_run & ~run_q;

   // hold frequency latch and zero-force
   logic hold_q;
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) hold_q <= 1'b0;
      else         hold_q <= hold;
   end

   // a hold taken while stopped latches nothing: the ramp output means nothing then
   logic hold_rise;
   assign hold_rise = hold & ~hold_q & (state_q != DICS_ST_IDLE);

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         held_reference_memory_q <= '0;
         nv_loaded_q             <= 1'b0;
      end else if (hold_rise) begin
         held_reference_memory_q <= ramp_freq_i;
      end else if (nv_valid_i & ~nv_loaded_q) begin
         nv_loaded_q             <= 1'b1;
         if (mem_on) held_reference_memory_q <= nv_freq_i;
      end
   end

   // store the latched value once, when hold rises while memory on
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         nv_write_o <= 1'b0;
         nv_data_o  <= '0;
      end else begin
         nv_write_o <= mem_on & hold_rise;
         // data only moves with a store, so the store never sees a ramp in motion
         if (mem_on & hold_rise) nv_data_o <= ramp_freq_i;
      end
   end

   logic fz_q;
   always_ff @(posedge ref_clk_i) begin
      if (reset_i)             fz_q <= 1'b0;
      else if (run_rise)       fz_q <= hold & ~mem_on;
      else if (!hold | !sel_run) fz_q <= 1'b0;
   end

   // zero stands while both hold and run stand; dropping either releases it
   logic fz_now;
   assign fz_now = hold & sel_run & (fz_q | (run_rise & ~mem_on));

   // registered command outputs
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         freq_ref_o       <= '0;
         run_cmd_o        <= 1'b0;
         output_inhibit_o <= 1'b0;
         ramp_hold_o      <= 1'b0;
         speed_search_o   <= 1'b0;
         force_zero_o     <= 1'b0;
         active_ref_src_o <= DICS_SRC_KEYPAD;
         active_run_src_o <= DICS_SRC_KEYPAD;
      end else begin
         if (fz_now) freq_ref_o <= '0;
         else if (state_q == DICS_ST_SEARCH) freq_ref_o <= bb_freq_q;
         else if (hold | (run_rise & mem_on)) freq_ref_o <= held_reference_memory_q;
         else freq_ref_o <= sel_ref;
         run_cmd_o        <= sel_run;
         output_inhibit_o <= inhibit;
         ramp_hold_o      <= hold;
         // search is masked in the cycle an inhibit re-arrives
         speed_search_o   <= (state_q == DICS_ST_SEARCH) & ~inhibit;
         force_zero_o     <= fz_now;
         active_ref_src_o <= ref_src;
         active_run_src_o <= run_src;
      end
   end

   // apb register file: zero-wait, writes take effect on the access edge
   logic       wr_en;
   logic [3:0] term_idx;
   logic       term_hit;
   assign wr_en    = psel_i & penable_i & pwrite_i;
   assign term_hit = (paddr_i >= `DICS_ADDR_TERM_BASE) && (paddr_i <= `DICS_ADDR_TERM_LAST) &&
                     (paddr_i[1:0] == 2'h0);
   assign term_idx = 4'((paddr_i - `DICS_ADDR_TERM_BASE) >> 2);

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         freq_ref_source_sel_q  <= dics_src_t'(`DICS_SRC_RESET);
         run_cmd_source_sel_q   <= dics_src_t'(`DICS_SRC_RESET);
         hold_freq_memory_sel_q <= `DICS_MEM_RESET;
         key_remote_q           <= `DICS_KEY_REMOTE_RESET;
         keypad_freq_q          <= '0;
      end else if (wr_en) begin
         if (paddr_i == `DICS_ADDR_CTRL) begin
            freq_ref_source_sel_q  <= dics_src_t'(pwdata_i[`DICS_CTRL_FREQ_LSB +: 2]);
            run_cmd_source_sel_q   <= dics_src_t'(pwdata_i[`DICS_CTRL_RUN_LSB +: 2]);
            hold_freq_memory_sel_q <= pwdata_i[`DICS_CTRL_MEM_BIT];
            if (!lr_assigned) key_remote_q <= pwdata_i[`DICS_CTRL_KEY_BIT];
         end else if (paddr_i == `DICS_ADDR_FREQ_IN) begin
            keypad_freq_q <= pwdata_i[`DICS_FREQ_W-1:0];
         end
      end else if (keypad_local_key_i & ~lr_assigned) begin
         key_remote_q <= ~key_remote_q;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         for (int i = 0; i < N; i++) begin
            input_terminal_function_sel_q[i*`DICS_FUNC_W +: `DICS_FUNC_W] <= `DICS_FN_RESET;
         end
      end else if (wr_en & term_hit) begin
         input_terminal_function_sel_q[term_idx*`DICS_FUNC_W +: `DICS_FUNC_W] <=
            pwdata_i[`DICS_FUNC_W-1:0];
      end
   end

   logic        addr_ok;
   logic [31:0] rd;
   always_comb begin
      addr_ok = 1'b1;
      rd      = '0;
      if (term_hit) begin
         rd[`DICS_FUNC_W-1:0] =
            input_terminal_function_sel_q[term_idx*`DICS_FUNC_W +: `DICS_FUNC_W];
      end else begin
         case (paddr_i)
            `DICS_ADDR_CTRL: begin
               rd[`DICS_CTRL_FREQ_LSB +: 2] = freq_ref_source_sel_q;
               rd[`DICS_CTRL_RUN_LSB +: 2]  = run_cmd_source_sel_q;
               rd[`DICS_CTRL_MEM_BIT]       = hold_freq_memory_sel_q;
               rd[`DICS_CTRL_KEY_BIT]       = key_remote_q;
            end
            `DICS_ADDR_STATUS:   rd[11:0] = {fz_q, remote, hold, inhibit, state_q,
                                             rev_in, fwd_in, term[3:0]};
            `DICS_ADDR_FREQ_IN:  rd[`DICS_FREQ_W-1:0] = keypad_freq_q;
            `DICS_ADDR_OUT_FREQ: rd[`DICS_FREQ_W-1:0] = freq_ref_o;
            `DICS_ADDR_HELD:     rd[`DICS_FREQ_W-1:0] = held_reference_memory_q;
            default:             addr_ok = 1'b0;
         endcase
      end
   end

   assign pready_o  = 1'b1;
   assign prdata_o  = rd;
   assign pslverr_o = psel_i & penable_i & ~addr_ok;
endmodule : dics_top

// *** tb/dics_contact_model.sv ***
// far side: contact wiring and the non-volatile frequency store
// assumes the bench sets contact levels at the clock edge
`timescale 1ns/1ps
module dics_contact_model (
   // requests from the bench
   input  wire logic        ref_clk_i,
   input  wire logic [9:0]  term_req_i,
   input  wire logic        fwd_req_i,
   input  wire logic        rev_req_i,
   // store side
   input  wire logic        nv_write_i,
   input  wire logic [15:0] nv_data_i,
   // to the block
   output logic [9:0]       multi_input_o,
   output logic             fwd_o,
   output logic             rev_o,
   output logic [15:0]      nv_freq_o,
   output logic             nv_valid_o
);
   // plain wiring: the block's own synchronisers absorb the contact timing
   assign multi_input_o = term_req_i;
   assign fwd_o         = fwd_req_i;
   assign rev_o         = rev_req_i;
   initial nv_freq_o = 16'h0000;
   initial nv_valid_o = 1'b0;
   // nothing stored yet: the read lines keep changing
   always @(posedge ref_clk_i) begin
      if (nv_write_i) begin
         nv_freq_o  <= nv_data_i;
         nv_valid_o <= 1'b1;
      end else if (!nv_valid_o) begin
         nv_freq_o <= ~nv_freq_o;
      end
   end
endmodule : dics_contact_model

// *** tb/dics_monitor.sv ***
// concurrent checks on the command selector ports
// bound into dics_top; one clock domain, sync reset
`timescale 1ns/1ps
`include "dics_defs.svh"
module dics_monitor (
   input wire logic                    ref_clk_i,
   input wire logic                    reset_i,
   input wire logic                    psel_i,
   input wire logic                    penable_i,
   input wire logic [11:0]             paddr_i,
   input wire logic                    pslverr_o,
   input wire logic                    nv_write_o,
   input wire logic [`DICS_FREQ_W-1:0] nv_data_o,
   input wire logic [`DICS_FREQ_W-1:0] freq_ref_o,
   input wire logic                    run_cmd_o,
   input wire logic                    output_inhibit_o,
   input wire logic                    ramp_hold_o,
   input wire logic                    speed_search_o,
   input wire logic                    force_zero_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (reset_i);
   wire acc = psel_i && penable_i;
   a_slverr_past_last: assert property (acc && paddr_i > `DICS_ADDR_TERM_LAST |-> pslverr_o)
      else $error("no error beyond last selector");
   a_term_sel_ok: assert property (acc && paddr_i inside {[`DICS_ADDR_TERM_BASE:`DICS_ADDR_TERM_LAST]}
      && paddr_i[1:0] == 2'h0 |-> !pslverr_o)
      else $error("selector access refused");
   a_zero_ref: assert property (force_zero_o |-> freq_ref_o == 16'h0000)
      else $error("forced zero but reference not zero");
   a_force_hold: assert property (force_zero_o |-> ramp_hold_o && run_cmd_o)
      else $error("forced zero without hold and run");
   a_nv_hold: assert property (nv_write_o |-> ##[0:2] ramp_hold_o)
      else $error("store written without hold");
   a_nv_pulse: assert property (nv_write_o |=> !nv_write_o)
      else $error("store write not a pulse");
   a_search_free: assert property (speed_search_o |-> !output_inhibit_o)
      else $error("search while inhibited");
   a_hold_stable: assert property (ramp_hold_o && $past(ramp_hold_o) |-> $stable(nv_data_o))
      else $error("held value moved during hold");
   c_inhibit: cover property ($fell(output_inhibit_o));
   c_hold: cover property (nv_write_o);
   c_zero: cover property (force_zero_o);
endmodule : dics_monitor
bind dics_top dics_monitor u_mon (.ref_clk_i, .reset_i, .psel_i, .penable_i, .paddr_i,
   .pslverr_o, .nv_write_o, .nv_data_o, .freq_ref_o, .run_cmd_o, .output_inhibit_o,
   .ramp_hold_o, .speed_search_o, .force_zero_o);

// *** tb/dics_top_test.sv ***
// self-checking bench for the command selector
// assumes dics_top with zero-wait apb and 3-edge contact latency
`timescale 1ns/1ps
`include "dics_defs.svh"
module dics_top_test;
   import dics_pkg::*;
   logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
   logic [11:0] pa = 12'h000;
   logic [31:0] pwd = 32'h0, rd, prdata;
   logic er, pready, pslverr, key = 1'b0, sdone = 1'b0, fwd = 1'b0, rev = 1'b0;
   logic [9:0] term = 10'h000, mi;
   logic [15:0] ana = 16'h1234, ramp = 16'h0000, nvf, nvd, fref;
   logic fw, rv, nvv, nvw, run, inh, hold, srch, fz;
   dics_src_t rsrc, csrc;
   int n_errors = 0, n_checks = 0, cyc = 0;
   initial forever #2.5 clk = ~clk;
   dics_contact_model u_far (.ref_clk_i(clk), .term_req_i(term), .fwd_req_i(fwd),
      .rev_req_i(rev),
      .nv_write_i(nvw), .nv_data_i(nvd), .multi_input_o(mi), .fwd_o(fw),
      .rev_o(rv), .nv_freq_o(nvf), .nv_valid_o(nvv));
   dics_top DUT (.ref_clk_i(clk), .reset_i(rst), .psel_i(psel), .penable_i(pen),
      .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .multi_input_i(mi), .forward_run_input_i(fw),
      .reverse_run_input_i(rv), .keypad_local_key_i(key), .keypad_run_i(1'b0),
      .serial_run_i(1'b0), .option_run_i(1'b0), .analog_ref_i(ana),
      .serial_ref_i(16'h5A5A), .option_ref_i(16'h0000), .ramp_freq_i(ramp),
      .search_done_i(sdone), .nv_freq_i(nvf), .nv_valid_i(nvv), .nv_write_o(nvw),
      .nv_data_o(nvd), .active_ref_src_o(rsrc), .active_run_src_o(csrc),
      .freq_ref_o(fref), .run_cmd_o(run), .output_inhibit_o(inh), .ramp_hold_o(hold),
      .speed_search_o(srch), .force_zero_o(fz));
   task report_and_stop;
      if (n_errors == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : report_and_stop
   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      n_checks++;
      if (s !== e) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task wt(input int n);
      repeat (n) @(posedge clk);
   endtask : wt
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1; pen <= 1'b0; pwr <= w; pa <= a; pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0; pen <= 1'b0;
   endtask : apb
   task t_defaults;
      apb(0, `DICS_ADDR_CTRL, 0); chk("ctrl", rd, 32'h0000_0211);
      apb(0, `DICS_ADDR_TERM_LAST, 0); chk("sel9", rd, 32'h0000_000F);
      apb(1, `DICS_ADDR_TERM_LAST, 32'h0A); apb(0, `DICS_ADDR_TERM_LAST, 0);
      chk("sel9 rw", rd, 32'h0000_000A);
      apb(1, `DICS_ADDR_TERM_LAST, 32'h0F);
      apb(0, 12'h068, 0); chk("sel10 err", {rd[30:0], er}, 32'h1);
   endtask : t_defaults
   task t_sources;
      for (int c = 0; c < 4; c++) begin
         apb(1, `DICS_ADDR_CTRL, 32'h200 | c | (c << 4)); wt(3);
         chk("ref src", rsrc, c);
         chk("run src", csrc, c);
      end
   endtask : t_sources
   task t_local_remote;
      apb(1, `DICS_ADDR_TERM_BASE, 32'h01); apb(1, `DICS_ADDR_CTRL, 32'h222); wt(4);
      chk("local", rsrc, 0);
      term[0] <= 1'b1; wt(3); chk("sync", rsrc, 0);
      wt(1); chk("remote", csrc, 2);
      key <= 1'b1; wt(1); key <= 1'b0; wt(3); chk("key", rsrc, 2);
      apb(1, `DICS_ADDR_CTRL, 32'h022); apb(0, `DICS_ADDR_CTRL, 0);
      chk("key bit", rd, 32'h222);
      term[0] <= 1'b0; apb(1, `DICS_ADDR_TERM_BASE, 32'h0F);
   endtask : t_local_remote
   task t_inhibit;
      apb(1, `DICS_ADDR_CTRL, 32'h211);
      apb(1, 12'h044, 32'h08); apb(1, 12'h048, 32'h09);
      term[2] <= 1'b1; fwd <= 1'b1; wt(5);
      chk("run", run, 1); chk("no inh", inh, 0);
      term[1] <= 1'b1; wt(4); chk("inh no", inh, 1);
      ana <= 16'h2222; term[1] <= 1'b0; wt(5);
      chk("search", srch, 1); chk("kept ref", fref, 16'h1234);
      sdone <= 1'b1; wt(1); sdone <= 1'b0; wt(2); chk("searched", srch, 0);
      term[2] <= 1'b0; wt(4); chk("inh nc", inh, 1);
      term[2] <= 1'b1; wt(4); sdone <= 1'b1; wt(1); sdone <= 1'b0; wt(2);
   endtask : t_inhibit
   task t_hold;
      apb(1, `DICS_ADDR_CTRL, 32'h311); apb(1, 12'h04C, 32'h0A);
      ramp <= 16'h0456; term[3] <= 1'b1; wt(5); chk("hold", hold, 1);
      chk("nv data", nvd, 16'h0456);
      ramp <= 16'h0999; wt(2); apb(0, `DICS_ADDR_HELD, 0);
      chk("held", rd, 32'h0456);
      term[3] <= 1'b0; wt(4); chk("ramp on", hold, 0);
   endtask : t_hold
   task t_restart;
      fwd <= 1'b0; apb(1, `DICS_ADDR_CTRL, 32'h211); term[3] <= 1'b1; wt(5);
      fwd <= 1'b1; wt(5); chk("fz", fz, 1); chk("zero", fref, 0);
      term[3] <= 1'b0; fwd <= 1'b0; wt(5);
      apb(1, `DICS_ADDR_CTRL, 32'h311); term[3] <= 1'b1; wt(5);
      fwd <= 1'b1; wt(5);
      chk("no fz", fz, 0); chk("held run", fref, 16'h0456);
      fwd <= 1'b0; rev <= 1'b1; wt(5); chk("rev run", run, 1);
   endtask : t_restart
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         report_and_stop;
      end
   end
   initial begin
      wt(5);
      rst <= 1'b0;
      t_defaults; t_sources; t_local_remote; t_inhibit; t_hold; t_restart;
      report_and_stop;
   end
endmodule : dics_top_test
